/* File: rtl/pms_consts.vh */
`ifndef PMS_CONSTS_VH
`define PMS_CONSTS_VH

// clock and step timing
`define PMS_CLK_HZ 40000000
`define PMS_TICK_HZ 10000
`define PMS_TICK_CYC (`PMS_CLK_HZ / `PMS_TICK_HZ)
`define PMS_MS_TICKS (`PMS_TICK_HZ / 1000)

// volume unit is 1/256 microliter, one motor step each
`define PMS_CHAMBER_VOL 32'h00006400
`define PMS_VOL_MIN (`PMS_CHAMBER_VOL / 10000)
`define PMS_PRIME_MAX (`PMS_CHAMBER_VOL * 1000)

// register byte offsets
`define PMS_OFF_CTRL 8'h00
`define PMS_OFF_STATUS 8'h04
`define PMS_OFF_DISP_VOL 8'h08
`define PMS_OFF_PRIME_LOAD_RATE 8'h34
`define PMS_OFF_POS 8'h38
`define PMS_OFF_DISPENSED 8'h3c
`define PMS_OFF_PRIMED 8'h40

// parameter slots, index is offset / 4
`define PMS_IX_DISP_VOL 2
`define PMS_IX_DISP_RATE 3
`define PMS_IX_LOAD_RATE 4
`define PMS_IX_THRESH 5
`define PMS_IX_DB_VOL 6
`define PMS_IX_DB_RATE 7
`define PMS_IX_DB_DWELL 8
`define PMS_IX_ACCEL 9
`define PMS_IX_TORQUE 10
`define PMS_IX_PRIME_VOL 11
`define PMS_IX_PRIME_RATE 12
`define PMS_IX_PRIME_LOAD 13

// control register fields
`define PMS_CTRL_REV 2
`define PMS_CTRL_DB_EN 3
`define PMS_CTRL_START 8
`define PMS_CTRL_STOP 9
`define PMS_MODE_DISP 2'h0
`define PMS_MODE_VAR 2'h1
`define PMS_MODE_METER 2'h2
`define PMS_MODE_PRIME 2'h3

// reset values
`define PMS_RST_CTRL 32'h00000000
`define PMS_RST_VOL 32'h00000a00
`define PMS_RST_RATE 32'h00000a00
`define PMS_RST_LOAD_RATE 32'h00001400
`define PMS_RST_DB_VOL 32'h00000080
`define PMS_RST_DWELL 32'h0000000a
`define PMS_RST_ACCEL 32'h00000040
`define PMS_RST_TORQUE 32'h00000080
`endif

/* File: rtl/pms_tick.v */
`timescale 1ns/1ps
`default_nettype none
`include "pms_consts.vh"

module pms_tick (
    // clock and reset
    input wire i_clk,
    input wire i_nrst,
    // enable pulses
    output reg o_tick,
    output reg o_ms
);
    localparam integer TICK_CYC = `PMS_TICK_CYC;
    localparam integer MS_TICKS = `PMS_MS_TICKS;
    localparam [11:0] TICK_LAST = TICK_CYC[11:0] - 12'h001;
    localparam [3:0] MS_LAST = MS_TICKS[3:0] - 4'h1;
    reg [11:0] cyc_reg;
    reg [3:0] sub_reg;

    // step tick and millisecond tick dividers
    always @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            cyc_reg <= 12'h000;
            sub_reg <= 4'h0;
            o_tick <= 1'b0;
            o_ms <= 1'b0;
        end else begin
            o_tick <= (cyc_reg == TICK_LAST);
            o_ms <= (cyc_reg == TICK_LAST) && (sub_reg == MS_LAST);
            if (cyc_reg == TICK_LAST) begin
                cyc_reg <= 12'h000;
                sub_reg <= (sub_reg == MS_LAST) ? 4'h0 : sub_reg + 4'h1;
            end else begin
                cyc_reg <= cyc_reg + 12'h001;
            end
        end
    end
endmodule
`default_nettype wire

/* File: rtl/pms_ramp.v */
`timescale 1ns/1ps
`default_nettype none
`include "pms_consts.vh"

module pms_ramp (
    // clock and reset
    input wire i_clk,
    input wire i_nrst,
    input wire i_tick,
    // move command
    input wire i_go,
    input wire i_halt,
    input wire [31:0] i_dist,
    input wire [31:0] i_rate,
    input wire [31:0] i_accel,
    // progress
    output reg o_step,
    output reg o_busy,
    output reg o_done
);
    localparam [31:0] TICK_HZ = `PMS_TICK_HZ;
    reg [31:0] left_reg, vel_reg, phase_reg, up_reg;
    reg decel_reg;
    reg [31:0] acc, target, vel_next, phase_sum;
    reg braking;

    // velocity profile, one step at most per tick
    always @* begin
        acc = (i_accel == 32'h0) ? 32'h1 : i_accel;
        target = (i_rate > TICK_HZ) ? TICK_HZ : i_rate;
        braking = decel_reg || (left_reg <= up_reg);
        if (braking) begin
            vel_next = (vel_reg > acc) ? vel_reg - acc : (decel_reg ? 32'h0 : acc);
        end else begin
            vel_next = (vel_reg + acc < target) ? vel_reg + acc : target;
        end
        phase_sum = phase_reg + vel_next;
    end

    // symmetric ramp: braking starts when left steps drop to or below climbing steps
    always @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            left_reg <= 32'h0;
            vel_reg <= 32'h0;
            phase_reg <= 32'h0;
            up_reg <= 32'h0;
            decel_reg <= 1'b0;
            o_step <= 1'b0;
            o_busy <= 1'b0;
            o_done <= 1'b0;
        end else begin
            o_step <= 1'b0;
            o_done <= 1'b0;
            if (i_go) begin
                o_done <= (i_dist == 32'h0);
                o_busy <= (i_dist != 32'h0);
                left_reg <= i_dist;
                vel_reg <= 32'h0;
                phase_reg <= 32'h0;
                up_reg <= 32'h0;
                decel_reg <= 1'b0;
            end else if (o_busy) begin
                if (i_halt) begin
                    decel_reg <= 1'b1; // stop brakes on the same slope
                end
                if (i_tick) begin
                    vel_reg <= vel_next;
                    if (phase_sum >= TICK_HZ) begin
                        phase_reg <= phase_sum - TICK_HZ;
                        o_step <= 1'b1;
                        left_reg <= left_reg - 32'h1;
                        if (!braking && vel_reg < target) begin
                            up_reg <= up_reg + 32'h1;
                        end
                        if (left_reg == 32'h1) begin
                            o_busy <= 1'b0;
                            o_done <= 1'b1;
                        end
                    end else begin
                        phase_reg <= phase_sum;
                        if (decel_reg && vel_next == 32'h0) begin
                            o_busy <= 1'b0;
                            o_done <= 1'b1;
                        end
                    end
                end
            end
        end
    end
endmodule
`default_nettype wire

/* File: rtl/pms_sequencer.v */
`timescale 1ns/1ps
`default_nettype none
`include "pms_consts.vh"

module pms_sequencer (
    // clock and reset
    input wire I_CLK_SYS,
    input wire I_NRST,
    // wishbone slave
    input wire I_WB_CYC,
    input wire I_WB_STB,
    input wire I_WB_WE,
    input wire [7:0] I_WB_ADR,
    input wire [3:0] I_WB_SEL,
    input wire [31:0] I_WB_DAT,
    output reg [31:0] O_WB_DAT,
    output reg O_WB_ACK,
    // operator and logic inputs
    input wire I_BTN_START,
    input wire I_BTN_STOP,
    input wire I_LIO_START,
    input wire I_LIO_STOP,
    input wire I_CONTACT_TRIGGER_INPUT,
    // actuator drive
    output reg O_STEP,
    output reg O_PISTON_FWD,
    output reg O_FLOW_REV,
    output reg [7:0] O_ILIM,
    // status
    output reg O_BUSY,
    output reg O_RELOAD
);
    // ****************************************
    // states
    // ****************************************
    localparam [4:0] ST_IDLE = 5'h01;
    localparam [4:0] ST_LOAD = 5'h02;
    localparam [4:0] ST_MOVE = 5'h04;
    localparam [4:0] ST_DRAW = 5'h08;
    localparam [4:0] ST_DWELL = 5'h10;
    localparam [31:0] CHAMBER = `PMS_CHAMBER_VOL;
    localparam [31:0] VOL_MIN = `PMS_VOL_MIN;
    localparam [31:0] PRIME_MAX = `PMS_PRIME_MAX;

    reg [31:0] cfg_reg [2:13];
    reg [31:0] ctrl_reg;
    reg [4:0] state_reg;
    reg [31:0] pos_reg, acc_reg, primed_reg, prime_left_reg, dwell_reg;
    reg [31:0] dist_reg, rate_reg;
    reg go_reg, halt_reg, fwd_reg, pend_reg, stopped_reg;
    reg btn_start_reg, btn_stop_reg, lio_start_reg, lio_stop_reg, trig_reg;
    wire tick, ms_tick, step, ramp_busy, ramp_done;
    integer i;

    // ****************************************
    // register bus
    // ****************************************
    wire wb_req = I_WB_CYC && I_WB_STB && !O_WB_ACK;
    wire wb_wr = wb_req && I_WB_WE;
    wire [5:0] wb_ix = I_WB_ADR[7:2];
    wire ctrl_wr = wb_wr && (I_WB_ADR == `PMS_OFF_CTRL);
    wire sw_start = ctrl_wr && I_WB_SEL[1] && I_WB_DAT[`PMS_CTRL_START];
    wire sw_stop = ctrl_wr && I_WB_SEL[1] && I_WB_DAT[`PMS_CTRL_STOP];

    // reset contents of the parameter slots
    function [31:0] rst_val;
        input integer ix;
        begin
            case (ix)
                `PMS_IX_DISP_VOL: rst_val = `PMS_RST_VOL;
                `PMS_IX_LOAD_RATE: rst_val = `PMS_RST_LOAD_RATE;
                `PMS_IX_THRESH: rst_val = `PMS_CHAMBER_VOL;
                `PMS_IX_DB_VOL: rst_val = `PMS_RST_DB_VOL;
                `PMS_IX_DB_DWELL: rst_val = `PMS_RST_DWELL;
                `PMS_IX_ACCEL: rst_val = `PMS_RST_ACCEL;
                `PMS_IX_TORQUE: rst_val = `PMS_RST_TORQUE;
                `PMS_IX_PRIME_VOL: rst_val = `PMS_CHAMBER_VOL;
                `PMS_IX_PRIME_LOAD: rst_val = `PMS_RST_LOAD_RATE;
                default: rst_val = `PMS_RST_RATE;
            endcase
        end
    endfunction

    // one-cycle ack, writes honour byte lanes, unmapped reads give zero
    always @(posedge I_CLK_SYS or negedge I_NRST) begin
        if (!I_NRST) begin
            O_WB_ACK <= 1'b0;
            O_WB_DAT <= 32'h0;
            ctrl_reg <= `PMS_RST_CTRL;
            for (i = 2; i <= 13; i = i + 1) begin
                cfg_reg[i] <= rst_val(i);
            end
        end else begin
            O_WB_ACK <= wb_req;
            if (ctrl_wr) begin
                for (i = 0; i < 4; i = i + 1) begin
                    if (I_WB_SEL[i]) begin
                        ctrl_reg[i*8 +: 8] <= I_WB_DAT[i*8 +: 8];
                    end
                end
                ctrl_reg[`PMS_CTRL_STOP:`PMS_CTRL_START] <= 2'h0; // pulse bits
            end else if (wb_wr && I_WB_ADR >= `PMS_OFF_DISP_VOL &&
                         I_WB_ADR <= `PMS_OFF_PRIME_LOAD_RATE && I_WB_ADR[1:0] == 2'h0) begin
                for (i = 0; i < 4; i = i + 1) begin
                    if (I_WB_SEL[i]) begin
                        cfg_reg[wb_ix][i*8 +: 8] <= I_WB_DAT[i*8 +: 8];
                    end
                end
            end
            if (wb_req && !I_WB_WE) begin
                if (I_WB_ADR == `PMS_OFF_CTRL) begin
                    O_WB_DAT <= ctrl_reg;
                end else if (I_WB_ADR == `PMS_OFF_STATUS) begin
                    O_WB_DAT <= {24'h0, O_RELOAD, O_BUSY, 1'b0, state_reg};
                end else if (I_WB_ADR >= `PMS_OFF_DISP_VOL &&
                             I_WB_ADR <= `PMS_OFF_PRIME_LOAD_RATE && I_WB_ADR[1:0] == 2'h0) begin
                    O_WB_DAT <= cfg_reg[wb_ix];
                end else if (I_WB_ADR == `PMS_OFF_POS) begin
                    O_WB_DAT <= pos_reg;
                end else if (I_WB_ADR == `PMS_OFF_DISPENSED) begin
                    O_WB_DAT <= acc_reg;
                end else if (I_WB_ADR == `PMS_OFF_PRIMED) begin
                    O_WB_DAT <= primed_reg;
                end else begin
                    O_WB_DAT <= 32'h0;
                end
            end
        end
    end

    // ****************************************
    // settings seen by the sequencer
    // ****************************************
    wire [1:0] mode = ctrl_reg[1:0];
    wire is_prime = (mode == `PMS_MODE_PRIME);
    wire is_meter = (mode == `PMS_MODE_METER);
    wire db_en = ctrl_reg[`PMS_CTRL_DB_EN] && !is_prime;
    wire [31:0] db_vol = db_en ? cfg_reg[`PMS_IX_DB_VOL] : 32'h0;
    wire [31:0] thresh = cfg_reg[`PMS_IX_THRESH];
    wire [31:0] pvol = cfg_reg[`PMS_IX_PRIME_VOL];
    wire [31:0] dvol = cfg_reg[`PMS_IX_DISP_VOL];
    // out-of-range volumes are pulled to the nearest legal value
    wire [31:0] disp_vol = (dvol < VOL_MIN) ? VOL_MIN :
        (dvol > CHAMBER) ? CHAMBER : dvol;
    wire [31:0] prime_vol = (pvol < VOL_MIN) ? VOL_MIN :
        (pvol > PRIME_MAX) ? PRIME_MAX : pvol;
    wire [31:0] prime_src = (state_reg == ST_IDLE) ? prime_vol : prime_left_reg;
    wire [31:0] prime_chunk = (prime_src < pos_reg) ? prime_src : pos_reg;
    wire [31:0] meter_dist = (pos_reg > db_vol) ? pos_reg - db_vol : 32'h0;
    wire [31:0] db_room = CHAMBER - pos_reg;
    wire [31:0] db_dist = (db_vol < db_room) ? db_vol : db_room;

    // reload decision from the position counter and accumulator
    wire thresh_hit = (acc_reg >= thresh);
    wire need_reload = is_prime ? (pos_reg == 32'h0) :
        is_meter ? (thresh_hit || meter_dist == 32'h0) :
        (pos_reg < disp_vol || thresh_hit);
    wire [31:0] move_dist = is_prime ? prime_chunk : is_meter ? meter_dist : disp_vol;
    wire [31:0] move_rate = is_prime ? cfg_reg[`PMS_IX_PRIME_RATE] :
        cfg_reg[`PMS_IX_DISP_RATE];
    wire [31:0] load_rate = is_prime ? cfg_reg[`PMS_IX_PRIME_LOAD] :
        cfg_reg[`PMS_IX_LOAD_RATE];

    // ****************************************
    // start and stop sources
    // ****************************************
    // pins are synchronous; only rising edges count
    wire trig_start = I_CONTACT_TRIGGER_INPUT && !trig_reg && !is_prime;
    wire start_any = sw_start || (I_BTN_START && !btn_start_reg) ||
        (I_LIO_START && !lio_start_reg) || trig_start;
    wire stop_any = sw_stop || (I_BTN_STOP && !btn_stop_reg) ||
        (I_LIO_STOP && !lio_stop_reg);

    always @(posedge I_CLK_SYS or negedge I_NRST) begin
        if (!I_NRST) begin
            btn_start_reg <= 1'b0;
            btn_stop_reg <= 1'b0;
            lio_start_reg <= 1'b0;
            lio_stop_reg <= 1'b0;
            trig_reg <= 1'b0;
        end else begin
            btn_start_reg <= I_BTN_START;
            btn_stop_reg <= I_BTN_STOP;
            lio_start_reg <= I_LIO_START;
            lio_stop_reg <= I_LIO_STOP;
            trig_reg <= I_CONTACT_TRIGGER_INPUT;
        end
    end

    // ****************************************
    // motion engine
    // ****************************************
    pms_tick u_tick (
        .i_clk(I_CLK_SYS),
        .i_nrst(I_NRST),
        .o_tick(tick),
        .o_ms(ms_tick)
    );

    pms_ramp u_ramp (
        .i_clk(I_CLK_SYS),
        .i_nrst(I_NRST),
        .i_tick(tick),
        .i_go(go_reg),
        .i_halt(halt_reg),
        .i_dist(dist_reg),
        .i_rate(rate_reg),
        .i_accel(cfg_reg[`PMS_IX_ACCEL]),
        .o_step(step),
        .o_busy(ramp_busy),
        .o_done(ramp_done)
    );

    // ****************************************
    // sequencer
    // ****************************************
    // one move at a time: every change into LOAD, MOVE or DRAW launches the ramp with a go pulse
    always @(posedge I_CLK_SYS or negedge I_NRST) begin
        if (!I_NRST) begin
            state_reg <= ST_IDLE;
            pos_reg <= `PMS_CHAMBER_VOL;
            acc_reg <= 32'h0;
            primed_reg <= 32'h0;
            prime_left_reg <= 32'h0;
            dwell_reg <= 32'h0;
            dist_reg <= 32'h0;
            rate_reg <= 32'h0;
            go_reg <= 1'b0;
            halt_reg <= 1'b0;
            fwd_reg <= 1'b1;
            pend_reg <= 1'b0;
            stopped_reg <= 1'b0;
        end else begin
            go_reg <= 1'b0;
            halt_reg <= 1'b0;
            // position counter: forward empties the chamber
            if (step && fwd_reg) begin
                pos_reg <= pos_reg - 32'h1;
                acc_reg <= acc_reg + 32'h1;
                if (is_prime) begin
                    primed_reg <= primed_reg + 32'h1;
                    prime_left_reg <= prime_left_reg - 32'h1;
                end
            end else if (step) begin
                pos_reg <= pos_reg + 32'h1;
            end
            case (state_reg)
                ST_IDLE: begin
                    if (start_any) begin
                        stopped_reg <= 1'b0;
                        go_reg <= 1'b1;
                        if (is_prime) begin
                            prime_left_reg <= prime_vol;
                            primed_reg <= 32'h0;
                        end
                        if (need_reload) begin
                            // refill first, then run the requested move
                            pend_reg <= 1'b1;
                            state_reg <= ST_LOAD;
                            dist_reg <= CHAMBER - pos_reg;
                            rate_reg <= load_rate;
                            fwd_reg <= 1'b0;
                        end else begin
                            state_reg <= ST_MOVE;
                            dist_reg <= move_dist;
                            rate_reg <= move_rate;
                            fwd_reg <= 1'b1;
                        end
                    end
                end
                ST_LOAD: begin
                    if (stop_any) begin
                        stopped_reg <= 1'b1; // the fill itself completes
                    end
                    if (ramp_done) begin
                        acc_reg <= 32'h0;
                        pend_reg <= 1'b0;
                        if (pend_reg && !stopped_reg && !stop_any) begin
                            go_reg <= 1'b1;
                            state_reg <= ST_MOVE;
                            dist_reg <= is_prime ? ((prime_left_reg < CHAMBER) ?
                                prime_left_reg : CHAMBER) : move_dist;
                            rate_reg <= move_rate;
                            fwd_reg <= 1'b1;
                        end else begin
                            state_reg <= ST_IDLE;
                        end
                    end
                end
                ST_MOVE: begin
                    if (stop_any && ramp_busy) begin
                        halt_reg <= 1'b1;
                        stopped_reg <= 1'b1;
                    end
                    if (ramp_done) begin
                        // the last step lands with done, so counters still lag by it
                        if (is_prime && !stopped_reg && prime_left_reg > {31'h0, step}) begin
                            // chamber spent mid prime: refill and carry on
                            go_reg <= 1'b1;
                            pend_reg <= 1'b1;
                            state_reg <= ST_LOAD;
                            dist_reg <= CHAMBER - pos_reg + {31'h0, step};
                            rate_reg <= load_rate;
                            fwd_reg <= 1'b0;
                        end else if (db_en && db_dist != 32'h0) begin
                            go_reg <= 1'b1;
                            state_reg <= ST_DRAW;
                            dist_reg <= db_dist;
                            rate_reg <= cfg_reg[`PMS_IX_DB_RATE];
                            fwd_reg <= 1'b0;
                        end else begin
                            state_reg <= ST_DWELL;
                            dwell_reg <= 32'h0;
                        end
                    end
                end
                ST_DRAW: begin
                    if (ramp_done) begin
                        state_reg <= ST_DWELL;
                        dwell_reg <= 32'h0;
                    end
                end
                ST_DWELL: begin
                    // starts are ignored until the dwell has run out
                    if (dwell_reg >= cfg_reg[`PMS_IX_DB_DWELL]) begin
                        state_reg <= ST_IDLE;
                    end else if (ms_tick) begin
                        dwell_reg <= dwell_reg + 32'h1;
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // ****************************************
    // pin outputs
    // ****************************************
    // all registered; step pulses in the same cycle as the counter moves
    always @(posedge I_CLK_SYS or negedge I_NRST) begin
        if (!I_NRST) begin
            O_STEP <= 1'b0;
            O_PISTON_FWD <= 1'b1;
            O_FLOW_REV <= 1'b0;
            O_ILIM <= 8'h00;
            O_BUSY <= 1'b0;
            O_RELOAD <= 1'b0;
        end else begin
            O_STEP <= step;
            O_PISTON_FWD <= fwd_reg;
            O_FLOW_REV <= ctrl_reg[`PMS_CTRL_REV];
            // keep current on through the final step, which comes with done
            O_ILIM <= (ramp_busy || step) ? cfg_reg[`PMS_IX_TORQUE][7:0] : 8'h00;
            O_BUSY <= (state_reg != ST_IDLE);
            O_RELOAD <= need_reload;
        end
    end
endmodule
`default_nettype wire

/* File: test/pms_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module pms_props (
    // watched ports
    input wire logic I_CLK_SYS,
    input wire logic I_NRST,
    input wire logic I_WB_CYC,
    input wire logic I_WB_STB,
    input wire logic I_LIO_START,
    input wire logic O_WB_ACK,
    input wire logic O_STEP,
    input wire logic O_BUSY,
    input wire logic [7:0] O_ILIM
);
    default clocking @(posedge I_CLK_SYS); endclocking
    default disable iff (!I_NRST);
    // bus answers one cycle after a request, for one cycle only
    property p_ack_ans; I_WB_CYC && I_WB_STB && !O_WB_ACK |=> O_WB_ACK; endproperty
    a_ack_ans: assert property (p_ack_ans) else $error("ack missing");
    property p_ack_one; O_WB_ACK |=> !O_WB_ACK; endproperty
    a_ack_one: assert property (p_ack_one) else $error("ack too long");
    property p_ack_why; O_WB_ACK |-> $past(I_WB_CYC && I_WB_STB); endproperty
    a_ack_why: assert property (p_ack_why) else $error("ack without request");
    // steps come on ticks, thousands of cycles apart
    property p_step_gap; O_STEP |=> !O_STEP [*8]; endproperty
    a_step_gap: assert property (p_step_gap) else $error("step too soon");
    property p_step_busy; O_STEP |-> O_BUSY; endproperty
    a_step_busy: assert property (p_step_busy) else $error("step idle");
    property p_ilim_on; O_STEP |-> O_ILIM != 8'h00; endproperty
    a_ilim_on: assert property (p_ilim_on) else $error("no current");
    property p_ilim_off; !O_BUSY && $past(!O_BUSY) |-> O_ILIM == 8'h00; endproperty
    a_ilim_off: assert property (p_ilim_off) else $error("idle current");
    property p_start; $rose(I_LIO_START) && !O_BUSY |-> ##[1:8] O_BUSY; endproperty
    a_start: assert property (p_start) else $error("start lost");
endmodule
`default_nettype wire

/* File: test/pms_actuator_model.sv */
`timescale 1ns/1ps
`default_nettype none
module pms_actuator_model (
    // drive from the sequencer
    input wire logic i_clk,
    input wire logic i_step,
    input wire logic i_fwd,
    input wire logic [7:0] i_ilim,
    // piston travel seen so far
    output var int o_fwd_steps,
    output var int o_rev_steps
);
    int nf = 0, nr = 0;
    assign o_fwd_steps = nf;
    assign o_rev_steps = nr;
    // an unpowered winding stalls, so such steps are lost
    always @(posedge i_clk) begin
        if (i_step && i_ilim != 8'h00 && i_fwd) nf <= nf + 1;
        if (i_step && i_ilim != 8'h00 && !i_fwd) nr <= nr + 1;
    end
endmodule
`default_nettype wire

/* File: test/pms_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk = 1'b0, nrst = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic ls = 1'b0, lp = 1'b0, tr = 1'b0, bs = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wd = 32'h0, got;
    wire logic [31:0] rd;
    wire logic ack, step, fwd, busy, rev, rl;
    wire logic [7:0] ilim;
    int fs, rs, err_count = 0, n_compared = 0;
    // reset values: address beside expected read
    logic [7:0] ra [7] = '{8'h04, 8'h08, 8'h10, 8'h24, 8'h28, 8'h38, 8'h80};
    logic [31:0] re [7] = '{32'h1, 32'ha00, 32'h1400, 32'h40, 32'h80, 32'h6400, 32'h0};
    always #12.5 clk = ~clk;
    pms_sequencer uut (.I_CLK_SYS(clk), .I_NRST(nrst), .I_WB_CYC(cyc), .I_WB_STB(stb),
        .I_WB_WE(we), .I_WB_ADR(adr), .I_WB_SEL(4'hf), .I_WB_DAT(wd), .O_WB_DAT(rd),
        .O_WB_ACK(ack), .I_BTN_START(bs), .I_BTN_STOP(1'b0), .I_LIO_START(ls),
        .I_LIO_STOP(lp), .I_CONTACT_TRIGGER_INPUT(tr), .O_STEP(step), .O_PISTON_FWD(fwd),
        .O_FLOW_REV(rev), .O_ILIM(ilim), .O_BUSY(busy), .O_RELOAD(rl));
    pms_actuator_model u_act (.i_clk(clk), .i_step(step), .i_fwd(fwd), .i_ilim(ilim),
        .o_fwd_steps(fs), .o_rev_steps(rs));
    // one classic cycle; waits for ack, takes data at that edge
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        {cyc, stb, we, adr, wd} <= {1'b1, 1'b1, w, a, d};
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        got = rd;
        {cyc, stb} <= 2'b00;
        if (n >= 50) err_count++;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        n_compared++;
        if (s !== e) begin
            err_count++;
            $display("BAD %s exp %h got %h", nm, e, s);
        end
    endtask
    // bounded wait for busy to reach a level
    task automatic waitb(input logic v, input int lim);
        for (int n = 0; n < lim && busy !== v; n++) @(posedge clk);
    endtask
    task automatic give_verdict();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        for (int i = 0; i < 7; i++) begin
            wb(1'b0, ra[i], 32'h0);
            chk("reset", re[i], got);
        end
        $display("reset test done");
        // fast ramp so one step per tick keeps the run short
        wb(1, 8'h08, 32'h1);
        wb(1, 8'h0c, 32'h2710);
        wb(1, 8'h1c, 32'h2710);
        wb(1, 8'h24, 32'h2710);
        wb(1, 8'h18, 32'h1);
        wb(1, 8'h20, 32'h0);
        wb(1, 8'h00, 32'h8);
        ls <= 1'b1;
        waitb(1'b1, 50);
        waitb(1'b0, 40000);
        chk("fwd steps", 2, fs);
        chk("drawback", 1, rs);
        wb(0, 8'h3c, 0);
        chk("dispensed", 32'h2, got);
        wb(0, 8'h38, 0);
        chk("position", 32'h63ff, got);
        $display("dispense test done");
        wb(1, 8'h00, 32'h7);
        @(posedge clk);
        chk("flow rev", 1, rev);
        tr <= 1'b1;
        waitb(1'b1, 12000);
        chk("prime trig", 0, busy);
        wb(1, 8'h00, 32'h0);
        tr <= 1'b0;
        @(posedge clk);
        chk("flow fwd", 0, rev);
        tr <= 1'b1;
        waitb(1'b1, 50);
        waitb(1'b0, 30000);
        chk("trig fwd", 4, fs);
        chk("no drawback", 1, rs);
        $display("trigger test done");
        // low threshold forces a refill of three steps before the dispense
        wb(1, 8'h14, 32'h2);
        @(posedge clk);
        chk("reload flag", 1, rl);
        bs <= 1'b1;
        waitb(1'b1, 50);
        waitb(1'b0, 40000);
        chk("refill steps", 4, rs);
        chk("after refill", 6, fs);
        wb(0, 8'h3c, 0);
        chk("acc cleared", 32'h2, got);
        wb(0, 8'h38, 0);
        chk("refilled pos", 32'h63fe, got);
        $display("reload test done");
        // a stop after the first step ends a sixteen step move early
        wb(1, 8'h14, 32'h6400);
        wb(1, 8'h08, 32'h10);
        bs <= 1'b0;
        ls <= 1'b0;
        @(posedge clk);
        ls <= 1'b1;
        waitb(1'b1, 50);
        for (int n = 0; n < 9000 && fs == 6; n++) @(posedge clk);
        lp <= 1'b1;
        waitb(1'b0, 20000);
        chk("stopped", 7, fs);
        $display("stop test done");
        give_verdict();
    end
    initial begin
        repeat (98000) @(posedge clk);
        err_count++;
        give_verdict();
    end
endmodule
bind pms_sequencer pms_props u_chk (.I_CLK_SYS(I_CLK_SYS), .I_NRST(I_NRST),
    .I_WB_CYC(I_WB_CYC), .I_WB_STB(I_WB_STB), .I_LIO_START(I_LIO_START),
    .O_WB_ACK(O_WB_ACK), .O_STEP(O_STEP), .O_BUSY(O_BUSY), .O_ILIM(O_ILIM));
`default_nettype wire
